// file: rtl/srs_pkg.sv
// Constants, register layout and state types for the supply and reset sequencer.
// Assumes a single 100 MHz system clock and the power-on event as master reset.
// Functional notes
// RULE1 - Rising supply holds core and pulls pin.
// RULE2 - Power-on exit sets power-on flag bit one.
// RULE3 - Every other reset clears the power-on flag.
// RULE4 - Other cause flags undefined while power-on flag.
// RULE5 - All resets restart fetch at address zero.
// RULE6 - Supply monitor enabled after power-on reset.
// RULE7 - Monitor enable survives all non-power-on resets.
// RULE8 - Low supply with monitor on resets core.
// RULE9 - Power-fail reset leaves data memory untouched.
// RULE10 - Unprotected flash erase or write forces reset.
// RULE11 - Release delay counter starts at supply good.
// RULE12 - Only power-on initialises flag and enable.
package srs_pkg;

    localparam int unsigned CLK_MHZ          = 100;
    localparam int unsigned RELEASE_DELAY_US = 100;
    localparam int unsigned RELEASE_CYCLES   = RELEASE_DELAY_US * CLK_MHZ;
    localparam int unsigned PULSE_CYCLES     = 8;

    localparam logic [7:0]  MON_CTRL_ADDR    = 8'hFF;
    localparam int unsigned MON_EN_BIT       = 7;
    localparam int unsigned MON_LVL_BIT      = 5;
    localparam logic        MON_EN_RESET     = 1'b1;
    localparam logic        MON_LVL_RESET    = 1'b0;
    localparam logic [15:0] FETCH_ADDR       = 16'h0000;

    // Reset cause register; the power-on flag sits in bit 1.
    typedef struct packed {
        logic rsv7;
        logic flashError;
        logic rsv5;
        logic software;
        logic rsv3;
        logic monitorFail;
        logic powerOnFlag;
        logic rsv0;
    } srs_cause_type;

    localparam srs_cause_type CAUSE_RESET = 8'h00;

    typedef enum logic [1:0] {
        ST_HOLD,
        ST_DELAY,
        ST_RUN,
        ST_PULSE
    } srs_state_type;

endpackage

// file: rtl/srs_reset_seq.sv
// Reset sequencer: supply comparator in, core reset and open-drain reset pin out.
// Assumes the comparator output is asynchronous and rst is the power-on event.
`timescale 1ns/1ps
module srs_reset_seq #(
    parameter int unsigned RELEASE_CYCLES = srs_pkg::RELEASE_CYCLES
) (
    // Clock and power-on reset
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    // Supply comparator and reset requests
    input  wire logic                   supplyAbove,
    input  wire logic                   softResetReq,
    input  wire logic                   flashOpReq,
    input  wire logic                   monitorSrcSel,
    // Special function register port
    input  wire logic [7:0]             sfrAddr,
    input  wire logic                   sfrWrEn,
    input  wire logic [7:0]             sfrWrData,
    output logic      [7:0]             sfrRdData,
    // Core and pin side
    output logic                        coreReset,
    output logic      [15:0]            fetchAddr,
    output logic                        rstPinOut,
    output logic                        rstPinOe,
    output srs_pkg::srs_cause_type      resetCauseReg
);

    localparam int unsigned CNT_W = $clog2(RELEASE_CYCLES + 1);

    srs_pkg::srs_state_type state_r;
    logic [CNT_W-1:0]       delayCnt_r;
    logic [3:0]             pulseCnt_r;
    logic                   supSync1_r;
    logic                   supOk_r;
    logic                   monEn_r;
    logic                   monLvl_r;
    logic                   porPending_r;
    logic                   coreReset_r;
    logic                   rstPinOe_r;
    logic                   rstPinOut_r;
    logic [15:0]            fetchAddr_r;
    logic [7:0]             sfrRdData_r;
    srs_pkg::srs_cause_type cause_r;
    logic                   monFail;
    logic                   flashBad;
    logic                   delayDone;

    assign sfrRdData     = sfrRdData_r;
    assign coreReset     = coreReset_r;
    assign fetchAddr     = fetchAddr_r;
    assign rstPinOut     = rstPinOut_r;
    assign rstPinOe      = rstPinOe_r;
    assign resetCauseReg = cause_r;

    // The comparator is analog and unclocked, so it is synchronised first.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            supSync1_r <= 1'b0;
            supOk_r    <= 1'b0;
        end else begin
            supSync1_r <= supplyAbove;
            supOk_r    <= supSync1_r;
        end
    end

    assign monFail   = monEn_r && !supOk_r; // see RULE8
    assign flashBad  = flashOpReq && !(monEn_r && monLvl_r && monitorSrcSel); // see RULE10
    assign delayDone = delayCnt_r == CNT_W'(RELEASE_CYCLES - 1);

    // Sequencer. Power-fail entry only asserts core reset and the pin; memory gets no clear.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r    <= srs_pkg::ST_HOLD; // see RULE1
            delayCnt_r <= '0;
            pulseCnt_r <= '0;
        end else begin
            case (state_r)
                srs_pkg::ST_HOLD: begin
                    delayCnt_r <= '0; // see RULE11
                    if (supOk_r) begin
                        state_r <= srs_pkg::ST_DELAY;
                    end
                end
                srs_pkg::ST_DELAY: begin
                    if (!supOk_r) begin
                        state_r <= srs_pkg::ST_HOLD;
                    end else if (delayDone) begin
                        state_r <= srs_pkg::ST_RUN; // see RULE11
                    end else begin
                        delayCnt_r <= delayCnt_r + CNT_W'(1);
                    end
                end
                srs_pkg::ST_RUN: begin
                    pulseCnt_r <= '0;
                    if (monFail) begin
                        state_r <= srs_pkg::ST_HOLD; // see RULE8 RULE9
                    end else if (softResetReq || flashBad) begin
                        state_r <= srs_pkg::ST_PULSE; // see RULE10
                    end
                end
                srs_pkg::ST_PULSE: begin
                    if (monFail) begin
                        state_r <= srs_pkg::ST_HOLD;
                    end else if (pulseCnt_r == 4'(srs_pkg::PULSE_CYCLES - 1)) begin
                        state_r <= srs_pkg::ST_RUN;
                    end else begin
                        pulseCnt_r <= pulseCnt_r + 4'h1;
                    end
                end
                default: state_r <= srs_pkg::ST_HOLD;
            endcase
        end
    end

    // Core reset and pin come from flops that change on the same edge as the state, decoded from its next value.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            coreReset_r <= 1'b1;
            rstPinOe_r  <= 1'b1;
            rstPinOut_r <= 1'b0;
            fetchAddr_r <= srs_pkg::FETCH_ADDR;
        end else begin
            rstPinOut_r <= 1'b0;
            fetchAddr_r <= srs_pkg::FETCH_ADDR; // see RULE5
            coreReset_r <= 1'b1;
            rstPinOe_r  <= 1'b1; // see RULE1 RULE8
            if ((state_r == srs_pkg::ST_DELAY && supOk_r && delayDone)
                || (state_r == srs_pkg::ST_RUN && !monFail && !softResetReq && !flashBad)
                || (state_r == srs_pkg::ST_PULSE && !monFail
                    && pulseCnt_r == 4'(srs_pkg::PULSE_CYCLES - 1))) begin
                coreReset_r <= 1'b0;
                rstPinOe_r  <= 1'b0;
            end
        end
    end

    // Only the power-on event initialises these; other resets never touch them.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            monEn_r      <= srs_pkg::MON_EN_RESET; // see RULE6 RULE12
            monLvl_r     <= srs_pkg::MON_LVL_RESET;
            porPending_r <= 1'b1;
        end else begin
            if (sfrWrEn && sfrAddr == srs_pkg::MON_CTRL_ADDR) begin
                monEn_r  <= sfrWrData[srs_pkg::MON_EN_BIT]; // see RULE7
                monLvl_r <= sfrWrData[srs_pkg::MON_LVL_BIT];
            end
            if (state_r == srs_pkg::ST_DELAY && supOk_r && delayDone) begin
                porPending_r <= 1'b0;
            end
        end
    end

    // Cause register: power-on sets only its flag, others clear it.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cause_r <= srs_pkg::CAUSE_RESET; // see RULE12
        end else if (state_r == srs_pkg::ST_DELAY && supOk_r && delayDone && porPending_r) begin
            cause_r             <= srs_pkg::CAUSE_RESET; // see RULE4
            cause_r.powerOnFlag <= 1'b1; // see RULE2
        end else if (state_r == srs_pkg::ST_RUN) begin
            if (monFail) begin
                cause_r             <= srs_pkg::CAUSE_RESET; // see RULE3
                cause_r.monitorFail <= 1'b1;
            end else if (softResetReq) begin
                cause_r          <= srs_pkg::CAUSE_RESET; // see RULE3
                cause_r.software <= 1'b1;
            end else if (flashBad) begin
                cause_r            <= srs_pkg::CAUSE_RESET; // see RULE3
                cause_r.flashError <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sfrRdData_r <= 8'h00;
        end else if (sfrAddr == srs_pkg::MON_CTRL_ADDR) begin
            sfrRdData_r <= 8'h00;
            sfrRdData_r[srs_pkg::MON_EN_BIT]  <= monEn_r;
            sfrRdData_r[srs_pkg::MON_LVL_BIT] <= monLvl_r;
        end else begin
            sfrRdData_r <= 8'h00;
        end
    end

    // A pulse that ends with the monitor off may release into a low supply, so only the
    // supply-driven states are held here.
    a_hold_low_supply: assert property (@(posedge ref_clk) disable iff (rst) // see RULE1
        !supOk_r && (state_r == srs_pkg::ST_HOLD || state_r == srs_pkg::ST_DELAY)
        |=> coreReset_r && rstPinOe_r && !rstPinOut_r)
        else $error("core or pin released while supply is low");

    a_por_flag_set: assert property (@(posedge ref_clk) disable iff (rst) // see RULE2
        state_r == srs_pkg::ST_DELAY && supOk_r && delayDone && porPending_r
        |=> cause_r == 8'h02 && !coreReset_r)
        else $error("power-on flag not set on release");

    a_por_flag_clear: assert property (@(posedge ref_clk) disable iff (rst) // see RULE3
        state_r == srs_pkg::ST_RUN && (softResetReq || flashBad || monFail)
        |=> !cause_r.powerOnFlag && coreReset_r)
        else $error("power-on flag kept over another reset");

    a_fetch_zero: assert property (@(posedge ref_clk) disable iff (rst) // see RULE5
        $fell(coreReset_r) |-> fetchAddr_r == 16'h0000)
        else $error("fetch address not zero at release");

    a_monitor_keep: assert property (@(posedge ref_clk) disable iff (rst) // see RULE7
        !(sfrWrEn && sfrAddr == srs_pkg::MON_CTRL_ADDR) |=> $stable(monEn_r))
        else $error("monitor enable changed without a write");

    a_monitor_trip: assert property (@(posedge ref_clk) disable iff (rst) // see RULE8
        state_r == srs_pkg::ST_RUN && monEn_r && !supOk_r
        |=> coreReset_r && rstPinOe_r ##1 state_r == srs_pkg::ST_HOLD || supOk_r)
        else $error("monitor trip did not reset the core");

    a_flash_guard: assert property (@(posedge ref_clk) disable iff (rst) // see RULE10
        state_r == srs_pkg::ST_RUN && !monFail && !softResetReq && flashBad
        |=> cause_r.flashError && coreReset_r [*2])
        else $error("unprotected flash access did not reset");

    a_release_delay: assert property (@(posedge ref_clk) disable iff (rst) // see RULE11
        $fell(coreReset_r) && $past(state_r) == srs_pkg::ST_DELAY
        |-> $past(delayCnt_r) == CNT_W'(RELEASE_CYCLES - 1))
        else $error("core released before the delay expired");

endmodule

// file: tb/srs_supply_model.sv
// Supply comparator and board reset line facing the reset sequencer.
// Assumes the bench commands the supply level and the board pulls the reset line up.
`timescale 1ns/1ps
module srs_supply_model (
    // Commanded supply and the sequencer's pin drive
    input  wire logic supplyGood,
    input  wire logic rstPinOut,
    input  wire logic rstPinOe,
    // Comparator output and wire level
    output logic      supplyAbove,
    output wire logic rstPinLevel
);
    // The comparator is asynchronous, so it switches away from any clock edge.
    initial supplyAbove = 1'b0;
    always @(supplyGood) supplyAbove <= #3 supplyGood;
    // Once released, the line floats up to the pull-up level.
    assign rstPinLevel = rstPinOe ? rstPinOut : 1'b1;
endmodule

// file: tb/tb.sv
// Self-checking bench for the supply and reset sequencer.
// Assumes a 100 MHz clock and a shortened release delay of 20 cycles.
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic [7:0] rdAddr;
        logic [7:0] expRd;
    } srs_row_type;
    srs_row_type rows [5] = '{'{8'hFF, 8'hFF, 8'hFF, 8'hA0}, '{8'hFF, 8'h00, 8'hFF, 8'h00},
        '{8'h10, 8'hFF, 8'hFF, 8'h00}, '{8'hFF, 8'hA0, 8'h10, 8'h00}, '{8'hFF, 8'h80, 8'hFF, 8'h80}};
    logic                   ref_clk = 1'b0, rst = 1'b1, supplyGood = 1'b0, sfrWrEn = 1'b0;
    logic                   softResetReq = 1'b0, flashOpReq = 1'b0, monitorSrcSel = 1'b0;
    logic [7:0]             sfrAddr = 8'h00, sfrWrData = 8'h00, sfrRdData;
    logic                   coreReset, rstPinOut, rstPinOe, supplyAbove, rstPinLevel;
    logic [15:0]            fetchAddr;
    srs_pkg::srs_cause_type resetCauseReg;
    int                     fails = 0, n_compared = 0, cnt;

    initial forever #5 ref_clk = ~ref_clk;
    srs_supply_model u_model (.supplyGood(supplyGood), .rstPinOut(rstPinOut),
        .rstPinOe(rstPinOe), .supplyAbove(supplyAbove), .rstPinLevel(rstPinLevel));
    srs_reset_seq #(.RELEASE_CYCLES(20)) DUT (.ref_clk(ref_clk), .rst(rst),
        .supplyAbove(supplyAbove), .softResetReq(softResetReq), .flashOpReq(flashOpReq),
        .monitorSrcSel(monitorSrcSel), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
        .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .coreReset(coreReset),
        .fetchAddr(fetchAddr), .rstPinOut(rstPinOut), .rstPinOe(rstPinOe),
        .resetCauseReg(resetCauseReg));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Waits a bounded time for the core reset to reach a level; cnt holds the edges taken.
    task automatic wait_core(input logic lvl);
        cnt = 0;
        while (coreReset !== lvl) begin
            tick(1);
            cnt++;
            if (cnt > 200) begin
                fails++;
                $display("timeout waiting for core reset");
                tally_and_finish();
            end
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfrAddr <= a;
        sfrWrData <= d;
        sfrWrEn <= 1'b1;
        @(posedge ref_clk);
        sfrWrEn <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        sfrAddr <= a;
        tick(2);
    endtask
    task automatic req(input logic flash);
        @(posedge ref_clk);
        flashOpReq <= flash;
        softResetReq <= ~flash;
        @(posedge ref_clk);
        flashOpReq <= 1'b0;
        softResetReq <= 1'b0;
        #1;
    endtask
    task automatic set_supply(input logic v);
        @(posedge ref_clk);
        supplyGood <= v;
    endtask
    task automatic power_up();
        @(posedge ref_clk);
        rst <= 1'b1;
        supplyGood <= 1'b0;
        tick(12);
        check(coreReset, 1'b1);
        check(rstPinLevel, 1'b0);
        check(fetchAddr, 16'h0000);
        @(posedge ref_clk);
        rst <= 1'b0;
        tick(6);
        check(coreReset, 1'b1);
        set_supply(1'b1);
        wait_core(1'b0);
        check(cnt >= 21 && cnt <= 25, 1'b1);
        check(resetCauseReg, 8'h02);
        check(rstPinLevel, 1'b1);
        rd(8'hFF);
        check(sfrRdData, 8'h80);
        $display("power-up test done");
    endtask

    initial begin
        power_up();
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].data);
            rd(rows[i].rdAddr);
            check(sfrRdData, rows[i].expRd);
        end
        $display("register rows done");
        req(1'b1);
        check(coreReset, 1'b1);
        check(resetCauseReg, 8'h40);
        wait_core(1'b0);
        wr(8'hFF, 8'hA0);
        @(posedge ref_clk);
        monitorSrcSel <= 1'b1;
        req(1'b1);
        tick(2);
        check(coreReset, 1'b0);
        @(posedge ref_clk);
        monitorSrcSel <= 1'b0;
        req(1'b1);
        check(coreReset, 1'b1);
        wait_core(1'b0);
        wr(8'hFF, 8'h20);
        @(posedge ref_clk);
        monitorSrcSel <= 1'b1;
        req(1'b1);
        check(coreReset, 1'b1);
        check(resetCauseReg, 8'h40);
        wait_core(1'b0);
        @(posedge ref_clk);
        monitorSrcSel <= 1'b0;
        $display("flash error test done");
        wr(8'hFF, 8'h00);
        req(1'b0);
        check(coreReset, 1'b1);
        check(resetCauseReg, 8'h10);
        check(fetchAddr, 16'h0000);
        wait_core(1'b0);
        rd(8'hFF);
        check(sfrRdData, 8'h00);
        set_supply(1'b0);
        tick(10);
        check(coreReset, 1'b0);
        set_supply(1'b1);
        tick(5);
        $display("software reset test done");
        wr(8'hFF, 8'h80);
        set_supply(1'b0);
        wait_core(1'b1);
        check(cnt <= 5, 1'b1);
        check(resetCauseReg, 8'h04);
        check(rstPinLevel, 1'b0);
        set_supply(1'b1);
        tick(10);
        set_supply(1'b0);
        tick(5);
        check(coreReset, 1'b1);
        set_supply(1'b1);
        wait_core(1'b0);
        check(cnt >= 21 && cnt <= 25, 1'b1);
        check(resetCauseReg.powerOnFlag, 1'b0);
        $display("monitor fail test done");
        power_up();
        tally_and_finish();
    end
endmodule
